// >>> hw/dbs_pkg.sv
// Purpose: shared constants and carriers for the device and bus status registers
// Assumes: 50 MHz system clock, 16-bit command frames sent lsb first
// Notes: transceiver channel 0 is can, channel 1 is lin
package dbs_pkg;
  localparam logic [6:0] ADDR_DEVICE_STATE_STATUS = 7'h43;
  localparam logic [6:0] ADDR_BUS_STAT = 7'h44;
  localparam logic [7:0] RST_DEVICE_STATE_STATUS = 8'h00;
  localparam logic [7:0] RST_BUS_STAT = 8'h00;
  localparam int FRAME_BITS = 16;
  localparam int MODE_BIT = 7;
  localparam logic [1:0] ST_CLEARED = 2'h0;
  localparam logic [1:0] ST_FAIL = 2'h1;
  localparam logic [1:0] ST_SLEEP = 2'h2;
  localparam logic [1:0] WD_MAX = 2'h2;
  localparam logic [1:0] CFG_1 = 2'h0;
  localparam logic [1:0] CFG_2 = 2'h1;
  localparam logic [1:0] CFG_4 = 2'h3;
  localparam logic [1:0] TRX_OFF = 2'h0;
  localparam logic [1:0] TRX_NORMAL = 2'h3;
  localparam logic [1:0] FC_NONE = 2'h0;
  localparam logic [1:0] FC_TSD = 2'h1;
  localparam logic [1:0] FC_TXD_DOM = 2'h2;
  localparam logic [1:0] FC_BUS_DOM = 2'h3;
  localparam int CLK_MHZ = 50;
  localparam int LIN_TO_MS = 20;
  localparam int CAN_TO_US = 2000;
  localparam int TXEN_NS = 10000;
  localparam int CNT_W = 21;
  localparam int LIN_TO_CYC = LIN_TO_MS * 1000 * CLK_MHZ;
  localparam int CAN_TO_CYC = CAN_TO_US * CLK_MHZ;
  localparam int TXEN_CYC = (TXEN_NS * CLK_MHZ + 999) / 1000;
  typedef struct packed {
    logic [1:0] state;
    logic [1:0] rsvd;
    logic [1:0] wd_miss;
    logic spi_fail;
    logic failure;
  } dbs_device_state_status_t;
  typedef struct packed {
    logic rsvd;
    logic [1:0] lin_code;
    logic can_to;
    logic swk_err;
    logic [1:0] can_code;
    logic can_low;
  } dbs_bus_stat_t;
  typedef struct packed {
    logic [7:0] data;
    logic clr;
    logic [6:0] addr;
  } dbs_frame_t;
endpackage

// >>> hw/dbs_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are slow against clk
// Notes: only the second stage is visible
`timescale 1ns/1ps
module dbs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule

// >>> hw/dbs_spi.sv
// Purpose: 16-bit command frame receiver with read data return
// Assumes: synchronised pins, sclk well below clk/4, mode 0, lsb first
// Notes: read byte leaves during the second half of the frame
`timescale 1ns/1ps
module dbs_spi (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk_s,
  input wire logic cs_n_s,
  input wire logic mosi_s,
  input wire logic [7:0] rd_data,
  output logic [6:0] rd_addr,
  output logic frame_ok,
  output logic frame_bad,
  output dbs_pkg::dbs_frame_t frame,
  output logic miso_o,
  output logic miso_oe
);
  logic sclk_d_r;
  logic cs_d_r;
  logic [4:0] bits_r;
  logic [15:0] sh_r;
  logic [7:0] tx_r;
  logic rise;
  logic fall;
  assign rise = sclk_s & ~sclk_d_r;
  assign fall = ~sclk_s & sclk_d_r;
  assign rd_addr = sh_r[6:0];
  assign miso_oe = ~cs_n_s;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_n_s;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst || cs_n_s) begin
      bits_r <= '0;
      sh_r <= '0;
    end else if (rise) begin
      sh_r[bits_r[3:0]] <= mosi_s;
      bits_r <= (bits_r == 5'h1f) ? bits_r : bits_r + 5'h01;
    end
  end
  // read data latched once the address byte is complete, so it is pre-clear
  always_ff @(posedge clk) begin
    if (sys_rst || cs_n_s) begin
      tx_r <= '0;
      miso_o <= 1'b0;
    end else if (fall && bits_r == 5'h08) begin
      miso_o <= rd_data[0];
      tx_r <= {1'b0, rd_data[7:1]};
    end else if (fall && bits_r > 5'h08) begin
      miso_o <= tx_r[0];
      tx_r <= {1'b0, tx_r[7:1]};
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_ok <= 1'b0;
      frame_bad <= 1'b0;
      frame <= '0;
    end else begin
      frame_ok <= cs_n_s & ~cs_d_r & (bits_r == 5'(dbs_pkg::FRAME_BITS));
      frame_bad <= cs_n_s & ~cs_d_r & (bits_r != 5'(dbs_pkg::FRAME_BITS));
      if (cs_n_s & ~cs_d_r) begin
        frame <= sh_r;
      end
    end
  end
endmodule

// >>> hw/dbs_status.sv
// Purpose: device state and bus communication status registers
// Assumes: event inputs are one-cycle pulses from logic on clk
// Notes: pins pass a two-flop synchroniser before use
`timescale 1ns/1ps
module dbs_status #(
  parameter int LIN_TO_CYC = dbs_pkg::LIN_TO_CYC,
  parameter int CAN_TO_CYC = dbs_pkg::CAN_TO_CYC,
  parameter int TXEN_CYC = dbs_pkg::TXEN_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  input wire logic restart_fail_evt,
  input wire logic fs_wake_evt,
  input wire logic stop_to_sleep_evt,
  input wire logic sleep_no_wake_evt,
  input wire logic sleep_entry_evt,
  input wire logic sleep_flags_pending_evt,
  input wire logic wd_trig_ok,
  input wire logic wd_trig_fail,
  input wire logic wd_stopped,
  input wire logic wd_stop_by_fail,
  input wire logic [1:0] dev_config,
  input wire logic fail_cfg_bit,
  input wire logic fo_release,
  output logic restart_req,
  output logic fail_output_pin,
  input wire logic [1:0] can_mode,
  input wire logic [1:0] lin_mode,
  input wire logic can_txd,
  input wire logic lin_txd,
  input wire logic can_bus_dom,
  input wire logic lin_bus_dom,
  input wire logic can_tsd,
  input wire logic lin_tsd,
  input wire logic can_supply_low,
  input wire logic lin_supply_low,
  input wire logic can_timeout_evt,
  input wire logic swk_active,
  input wire logic swk_error_evt,
  input wire logic swk_enable_req,
  output logic swk_enable,
  output logic can_tx_en,
  output logic lin_tx_en,
  output dbs_pkg::dbs_device_state_status_t device_state_status,
  output dbs_pkg::dbs_bus_stat_t bus_stat
);
  if (LIN_TO_CYC < 1 || CAN_TO_CYC < 1 || TXEN_CYC < 1 ||
      LIN_TO_CYC >= (1 << dbs_pkg::CNT_W) || CAN_TO_CYC >= (1 << dbs_pkg::CNT_W) ||
      TXEN_CYC >= (1 << dbs_pkg::CNT_W)) begin : g_bad_counts
    $error("dbs_status: cycle counts out of counter range");
  end

  logic sclk_s;
  logic cs_s;
  logic mosi_s;
  logic [1:0] txd_s;
  logic [1:0] bus_s;
  logic [1:0] low_s;
  // select enters inverted so the synchroniser's reset zero reads as deselected,
  // otherwise release of reset looks like a frame end and flags a bad command
  dbs_sync #(
    .W(9)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({spi_sclk, ~spi_cs_n, spi_mosi, lin_txd, can_txd, lin_bus_dom, can_bus_dom,
          lin_supply_low, can_supply_low}),
    .dout({sclk_s, cs_s, mosi_s, txd_s, bus_s, low_s})
  );

  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic frame_ok;
  logic frame_bad;
  dbs_pkg::dbs_frame_t frame;
  dbs_spi u_spi (
    .clk(clk),
    .sys_rst(sys_rst),
    .sclk_s(sclk_s),
    .cs_n_s(~cs_s),
    .mosi_s(mosi_s),
    .rd_data(rd_data),
    .rd_addr(rd_addr),
    .frame_ok(frame_ok),
    .frame_bad(frame_bad),
    .frame(frame),
    .miso_o(spi_miso_o),
    .miso_oe(spi_miso_oe)
  );

  // unmapped addresses belong to other status blocks, so they return zero here
  always_comb begin
    rd_data = 8'h00;
    if (rd_addr == dbs_pkg::ADDR_DEVICE_STATE_STATUS) begin
      rd_data = device_state_status;
    end else if (rd_addr == dbs_pkg::ADDR_BUS_STAT) begin
      rd_data = bus_stat;
    end
  end

  logic clr_dev;
  logic clr_bus;
  assign clr_dev = frame_ok & frame.clr & (frame.addr == dbs_pkg::ADDR_DEVICE_STATE_STATUS);
  assign clr_bus = frame_ok & frame.clr & (frame.addr == dbs_pkg::ADDR_BUS_STAT);

  // prior state: fail code outranks sleep code when both arrive together
  logic fail_code_evt;
  logic sleep_code_evt;
  assign fail_code_evt = restart_fail_evt | fs_wake_evt | stop_to_sleep_evt |
                         sleep_no_wake_evt;
  assign sleep_code_evt = sleep_entry_evt | sleep_flags_pending_evt;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      device_state_status.state <= dbs_pkg::RST_DEVICE_STATE_STATUS[7:6];
    end else if (fail_code_evt) begin
      device_state_status.state <= dbs_pkg::ST_FAIL;
    end else if (sleep_code_evt) begin
      device_state_status.state <= dbs_pkg::ST_SLEEP;
    end else if (clr_dev) begin
      device_state_status.state <= dbs_pkg::ST_CLEARED;
    end
  end

  assign device_state_status.rsvd = 2'h0;
  assign bus_stat.rsvd = 1'b0;

  // watchdog miss counter, cleared only by the hardware
  logic frozen_r;
  logic fail_one;
  logic freeze_cfg;
  logic [1:0] wd_inc;
  logic fo_act;
  assign fail_one = (dev_config == dbs_pkg::CFG_2) & fail_cfg_bit;
  assign freeze_cfg = (dev_config == dbs_pkg::CFG_2) | (dev_config == dbs_pkg::CFG_4);
  assign wd_inc = (device_state_status.wd_miss == dbs_pkg::WD_MAX) ? dbs_pkg::WD_MAX :
                  device_state_status.wd_miss + 2'h1;
  assign fo_act = wd_trig_fail & ~frozen_r & ~wd_trig_ok &
                  (fail_one ? (wd_inc == 2'h1) : (wd_inc == dbs_pkg::WD_MAX));
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      device_state_status.wd_miss <= dbs_pkg::RST_DEVICE_STATE_STATUS[3:2];
      frozen_r <= 1'b0;
    end else if (wd_trig_ok) begin
      device_state_status.wd_miss <= 2'h0;
      frozen_r <= 1'b0;
    end else if (wd_trig_fail && !frozen_r) begin
      device_state_status.wd_miss <= wd_inc;
      frozen_r <= freeze_cfg;
    end else if (wd_stopped && !wd_stop_by_fail && !frozen_r) begin
      device_state_status.wd_miss <= 2'h0;
    end
  end

  // a miss restarts the device unless frozen (CFG_2, CFG_4) or paired with a good trigger; only misses reaching the threshold drive the fail output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      restart_req <= 1'b0;
    end else begin
      restart_req <= wd_trig_fail & ~frozen_r & ~wd_trig_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fail_output_pin <= 1'b0;
    end else if (fo_act) begin
      fail_output_pin <= 1'b1;
    end else if (fo_release) begin
      fail_output_pin <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      device_state_status.failure <= dbs_pkg::RST_DEVICE_STATE_STATUS[0];
    end else if (fo_act) begin
      device_state_status.failure <= 1'b1;
    end else if (clr_dev) begin
      device_state_status.failure <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      device_state_status.spi_fail <= dbs_pkg::RST_DEVICE_STATE_STATUS[1];
    end else if (frame_bad) begin
      device_state_status.spi_fail <= 1'b1;
    end else if (clr_dev) begin
      device_state_status.spi_fail <= 1'b0;
    end
  end

  // transceiver fault supervision, channel 0 can, channel 1 lin
  logic [1:0] mode [2];
  logic [1:0] tsd;
  logic [1:0] low_live;
  logic [1:0] tx_en;
  logic [1:0] code_evt;
  logic [1:0] code_val [2];
  assign mode[0] = can_mode;
  assign mode[1] = lin_mode;
  assign tsd = {lin_tsd, can_tsd};

  for (genvar i = 0; i < 2; i++) begin : g_trx
    localparam logic [dbs_pkg::CNT_W-1:0] TO_LIM = dbs_pkg::CNT_W'(i == 0 ? CAN_TO_CYC :
                                                                  LIN_TO_CYC);
    localparam logic [dbs_pkg::CNT_W-1:0] EN_LIM = dbs_pkg::CNT_W'(TXEN_CYC);
    logic [dbs_pkg::CNT_W-1:0] txd_cnt_r;
    logic [dbs_pkg::CNT_W-1:0] bus_cnt_r;
    logic [dbs_pkg::CNT_W-1:0] en_cnt_r;
    logic txd_to_r;
    logic bus_to_r;
    logic blocked_r;
    logic tsd_d_r;
    logic active;
    logic idle;
    logic fault;
    logic txd_hit;
    logic bus_hit;
    logic tsd_rise;
    assign active = mode[i] == dbs_pkg::TRX_NORMAL;
    assign idle = ~mode[i][1];
    assign low_live[i] = low_s[i] & mode[i][1];
    assign fault = txd_to_r | bus_to_r | tsd[i] | low_live[i];
    assign txd_hit = active & ~txd_s[i] & ~txd_to_r & (txd_cnt_r == TO_LIM - 1'b1);
    assign bus_hit = active & bus_s[i] & ~bus_to_r & (bus_cnt_r == TO_LIM - 1'b1);
    assign tsd_rise = tsd[i] & ~tsd_d_r;
    assign tx_en[i] = active & ~blocked_r & ~fault;
    assign code_evt[i] = bus_hit | txd_hit | tsd_rise;
    assign code_val[i] = bus_hit ? dbs_pkg::FC_BUS_DOM :
                         txd_hit ? dbs_pkg::FC_TXD_DOM : dbs_pkg::FC_TSD;

    always_ff @(posedge clk) begin
      if (sys_rst || !active || txd_s[i] || txd_to_r) begin
        txd_cnt_r <= '0;
      end else begin
        txd_cnt_r <= txd_cnt_r + 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst || txd_s[i] || idle) begin
        txd_to_r <= 1'b0;
      end else if (txd_hit) begin
        txd_to_r <= 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst || !active || !bus_s[i] || bus_to_r) begin
        bus_cnt_r <= '0;
      end else begin
        bus_cnt_r <= bus_cnt_r + 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst || !bus_s[i] || idle) begin
        bus_to_r <= 1'b0;
      end else if (bus_hit) begin
        bus_to_r <= 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        tsd_d_r <= 1'b0;
      end else begin
        tsd_d_r <= tsd[i];
      end
    end

    // a fault holds the driver off until txd has been high for the enable time
    always_ff @(posedge clk) begin
      if (sys_rst || fault || !txd_s[i]) begin
        en_cnt_r <= '0;
      end else if (en_cnt_r != EN_LIM) begin
        en_cnt_r <= en_cnt_r + 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        blocked_r <= 1'b0;
      end else if (fault) begin
        blocked_r <= 1'b1;
      end else if (en_cnt_r == EN_LIM) begin
        blocked_r <= 1'b0;
      end
    end
  end

  assign can_tx_en = tx_en[0];
  assign lin_tx_en = tx_en[1];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_stat.can_code <= dbs_pkg::RST_BUS_STAT[2:1];
      bus_stat.lin_code <= dbs_pkg::RST_BUS_STAT[6:5];
    end else begin
      if (code_evt[0]) begin
        bus_stat.can_code <= code_val[0];
      end else if (clr_bus) begin
        bus_stat.can_code <= dbs_pkg::FC_NONE;
      end
      if (code_evt[1]) begin
        bus_stat.lin_code <= code_val[1];
      end else if (clr_bus) begin
        bus_stat.lin_code <= dbs_pkg::FC_NONE;
      end
    end
  end

  // level-set: the flag cannot be cleared while the supply stays low with can_mode bit 1 set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_stat.can_low <= dbs_pkg::RST_BUS_STAT[0];
    end else if (low_live[0]) begin
      bus_stat.can_low <= 1'b1;
    end else if (clr_bus) begin
      bus_stat.can_low <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_stat.can_to <= dbs_pkg::RST_BUS_STAT[4];
    end else if (can_timeout_evt) begin
      bus_stat.can_to <= 1'b1;
    end else if (clr_bus) begin
      bus_stat.can_to <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_stat.swk_err <= dbs_pkg::RST_BUS_STAT[3];
    end else if (swk_error_evt && swk_active) begin
      bus_stat.swk_err <= 1'b1;
    end else if (clr_bus) begin
      bus_stat.swk_err <= 1'b0;
    end
  end

  assign swk_enable = swk_enable_req & ~bus_stat.swk_err;
endmodule

// >>> verif/dbs_status_asserts.sv
// Purpose: port-level checks for the device and bus status registers
// Assumes: event inputs are single-cycle pulses on clk
// Notes: watches a subset of the top-level ports, bound by name
`timescale 1ns/1ps
module dbs_status_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic restart_fail_evt,
  input wire logic fs_wake_evt,
  input wire logic stop_to_sleep_evt,
  input wire logic sleep_no_wake_evt,
  input wire logic sleep_flags_pending_evt,
  input wire logic wd_trig_ok,
  input wire logic wd_trig_fail,
  input wire logic fail_cfg_bit,
  input wire logic fail_output_pin,
  input wire logic [1:0] can_mode,
  input wire logic can_supply_low,
  input wire logic can_timeout_evt,
  input wire logic swk_enable_req,
  input wire logic swk_enable,
  input wire logic can_tx_en,
  input wire dbs_pkg::dbs_device_state_status_t device_state_status,
  input wire dbs_pkg::dbs_bus_stat_t bus_stat
);
  logic fail_ev;
  assign fail_ev = restart_fail_evt | fs_wake_evt | stop_to_sleep_evt | sleep_no_wake_evt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rsvd_dev_zero: assert property (device_state_status.rsvd == 2'h0)
    else $error("device register reserved bits not zero");
  a_rsvd_bus_zero: assert property (bus_stat.rsvd == 1'b0)
    else $error("bus register reserved bit not zero");
  a_wd_never_three: assert property (device_state_status.wd_miss != 2'h3)
    else $error("watchdog miss count reached three");
  a_fail_code_set: assert property (fail_ev |=> device_state_status.state == dbs_pkg::ST_FAIL)
    else $error("failure event did not record fail code");
  a_sleep_code_set: assert property (sleep_flags_pending_evt && !fail_ev |=>
    device_state_status.state == dbs_pkg::ST_SLEEP) else $error("sleep code not recorded");
  a_wd_good_clear: assert property (wd_trig_ok && !wd_trig_fail |=> device_state_status.wd_miss == 2'h0)
    else $error("good trigger did not clear miss count");
  a_first_miss_quiet: assert property (!fail_cfg_bit && wd_trig_fail &&
    device_state_status.wd_miss == 2'h0 && !fail_output_pin |=> !fail_output_pin)
    else $error("first miss drove fail output");
  a_fo_sets_flag: assert property ($rose(fail_output_pin) |-> ##[0:1] device_state_status.failure)
    else $error("fail output without failure flag");
  a_spi_flag_hold: assert property (spi_cs_n [*8] ##0 device_state_status.spi_fail |=> device_state_status.spi_fail)
    else $error("bad command flag cleared without a frame");
  a_timeout_flag: assert property (can_timeout_evt |=> bus_stat.can_to)
    else $error("timeout event not recorded");
  a_swk_gate: assert property (swk_enable == (swk_enable_req && !bus_stat.swk_err))
    else $error("selective wake enable not gated by error");
  a_low_tx_off: assert property ((can_supply_low && can_mode[1]) [*5] |-> !can_tx_en)
    else $error("transmitter enabled during supply low");
  a_low_gated: assert property ($rose(bus_stat.can_low) |-> $past(can_mode[1]))
    else $error("supply low flagged with comparator off");
  c_timeout: cover property (can_timeout_evt ##1 bus_stat.can_to);
  c_wd_two: cover property (device_state_status.wd_miss == 2'h2);
  c_low_rise: cover property ($rose(bus_stat.can_low));
endmodule
bind dbs_status dbs_status_asserts i_chk (.*);

// >>> verif/dbs_host_model.sv
// Purpose: host controller issuing 16-bit command frames
// Assumes: sclk half period of five clk cycles, mode 0, lsb first
// Notes: mosi is inverted between frames so no stale bit looks valid
`timescale 1ns/1ps
module dbs_host_model (
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    {sclk, cs_n, mosi} = 3'h2;
  end
  // nbits other than 16 makes an invalid frame on purpose
  task automatic frame(input logic [15:0] cmd, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi <= cmd[i % 16];
      repeat (5) @(posedge clk);
      sclk <= 1'b1;
      if (i >= 8 && i < 16) rd[i - 8] = miso;
      repeat (5) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (5) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge clk);
  endtask
endmodule

// >>> verif/dbs_status_bench.sv
// Purpose: self-checking bench for the status register block
// Assumes: shortened timeout counts, host model as command source
// Notes: expected bytes are built from the register layout
`timescale 1ns/1ps
module dbs_status_bench;
  localparam logic [6:0] DEV = dbs_pkg::ADDR_DEVICE_STATE_STATUS;
  localparam logic [6:0] BUS = dbs_pkg::ADDR_BUS_STAT;
  logic clk, sys_rst, spi_sclk, spi_cs_n, spi_mosi, miso, spi_miso_o, spi_miso_oe;
  logic [11:0] ev;
  logic [1:0] dev_config, can_mode, lin_mode;
  logic fail_cfg_bit, wd_stop_by_fail, restart_req, fail_output_pin, swk_active;
  logic can_txd, lin_txd, can_bus_dom, lin_bus_dom, can_tsd, lin_tsd;
  logic can_supply_low, lin_supply_low, swk_enable_req, swk_enable, can_tx_en, lin_tx_en;
  dbs_pkg::dbs_device_state_status_t device_state_status;
  dbs_pkg::dbs_bus_stat_t bus_stat;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] restart_count = 8'h00;
  always @(posedge clk) begin
    if (restart_req) restart_count <= restart_count + 8'h01;
  end
  // released reply line idles high through a pull-up
  assign miso = spi_miso_oe ? spi_miso_o : 1'b1;
  dbs_status #(.LIN_TO_CYC(50), .CAN_TO_CYC(40), .TXEN_CYC(5)) i_dut (.*,
    .restart_fail_evt(ev[0]), .fs_wake_evt(ev[1]), .stop_to_sleep_evt(ev[2]),
    .sleep_no_wake_evt(ev[3]), .sleep_entry_evt(ev[4]), .sleep_flags_pending_evt(ev[5]),
    .wd_trig_ok(ev[6]), .wd_trig_fail(ev[7]), .wd_stopped(ev[8]), .fo_release(ev[9]),
    .can_timeout_evt(ev[10]), .swk_error_evt(ev[11]));
  dbs_host_model i_host (.clk(clk), .miso(miso), .sclk(spi_sclk), .cs_n(spi_cs_n),
    .mosi(spi_mosi));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic wrap_up;
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // generous ceiling: the whole sequence needs well under 10000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input int k);
    @(posedge clk) ev[k] <= 1'b1;
    @(posedge clk) ev[k] <= 1'b0;
    cyc(2);
  endtask
  task automatic acc(input logic [6:0] a, input logic c, input logic [7:0] exp);
    logic [7:0] d;
    i_host.frame({8'h00, c, a}, 16, d);
    chk(d, exp);
  endtask
  task automatic t_reset;
    chk(device_state_status, dbs_pkg::RST_DEVICE_STATE_STATUS);
    chk(bus_stat, dbs_pkg::RST_BUS_STAT);
    acc(DEV, 1'b0, dbs_pkg::RST_DEVICE_STATE_STATUS);
    acc(BUS, 1'b0, dbs_pkg::RST_BUS_STAT);
    acc(7'h45, 1'b0, 8'h00);
  endtask
  // four failure causes, then both sleep causes, each cleared by the host
  task automatic t_state;
    for (int k = 0; k < 6; k++) begin
      pulse(k);
      chk(device_state_status, (k < 4) ? 8'h40 : 8'h80);
      acc(DEV, 1'b1, (k < 4) ? 8'h40 : 8'h80);
      chk(device_state_status, 8'h00);
    end
  endtask
  task automatic t_wd;
    @(posedge clk) dev_config <= dbs_pkg::CFG_2;
    pulse(7);
    chk({7'h0, fail_output_pin}, 8'h00);
    chk(device_state_status, 8'h04);
    pulse(6);
    chk(device_state_status, 8'h00);
    @(posedge clk) fail_cfg_bit <= 1'b1;
    pulse(7);
    chk(device_state_status, 8'h05);
    pulse(7);
    chk(device_state_status, 8'h05);
    pulse(6);
    chk(device_state_status, 8'h01);
    pulse(9);
    @(posedge clk) dev_config <= dbs_pkg::CFG_1;
    pulse(7);
    pulse(7);
    chk(device_state_status, 8'h09);
    chk({7'h0, fail_output_pin}, 8'h01);
    pulse(7);
    chk(device_state_status, 8'h09);
    @(posedge clk) wd_stop_by_fail <= 1'b1;
    pulse(8);
    chk(device_state_status, 8'h09);
    @(posedge clk) wd_stop_by_fail <= 1'b0;
    pulse(8);
    chk(device_state_status, 8'h01);
    pulse(9);
    acc(DEV, 1'b1, 8'h01);
    chk(restart_count, 8'h05);
  endtask
  task automatic t_spi;
    logic [7:0] d;
    i_host.frame(16'h0043, 12, d);
    cyc(20);
    chk(device_state_status, 8'h02);
    acc(DEV, 1'b1, 8'h02);
    chk(device_state_status, 8'h00);
  endtask
  // transceiver faults: txd dominant, bus dominant, thermal, then lin txd
  task automatic t_trx;
    @(posedge clk) can_mode <= dbs_pkg::TRX_NORMAL;
    cyc(10);
    chk({7'h0, can_tx_en}, 8'h01);
    @(posedge clk) can_txd <= 1'b0;
    cyc(60);
    chk(bus_stat, 8'h04);
    chk({7'h0, can_tx_en}, 8'h00);
    @(posedge clk) can_txd <= 1'b1;
    cyc(3);
    chk({7'h0, can_tx_en}, 8'h00);
    cyc(12);
    chk({7'h0, can_tx_en}, 8'h01);
    acc(BUS, 1'b1, 8'h04);
    @(posedge clk) can_bus_dom <= 1'b1;
    cyc(60);
    chk(bus_stat, 8'h06);
    @(posedge clk) can_mode <= dbs_pkg::TRX_OFF;
    cyc(4);
    @(posedge clk) can_bus_dom <= 1'b0;
    @(posedge clk) can_mode <= dbs_pkg::TRX_NORMAL;
    cyc(15);
    chk({7'h0, can_tx_en}, 8'h01);
    acc(BUS, 1'b1, 8'h06);
    @(posedge clk) can_tsd <= 1'b1;
    cyc(3);
    chk(bus_stat, 8'h02);
    @(posedge clk) can_tsd <= 1'b0;
    acc(BUS, 1'b1, 8'h02);
    @(posedge clk) lin_mode <= dbs_pkg::TRX_NORMAL;
    @(posedge clk) lin_txd <= 1'b0;
    cyc(70);
    chk(bus_stat, 8'h40);
    chk({7'h0, lin_tx_en}, 8'h00);
    @(posedge clk) lin_txd <= 1'b1;
    cyc(15);
    chk({7'h0, lin_tx_en}, 8'h01);
    acc(BUS, 1'b1, 8'h40);
  endtask
  task automatic t_supply;
    @(posedge clk) can_mode <= 2'h1;
    @(posedge clk) can_supply_low <= 1'b1;
    cyc(10);
    chk(bus_stat, 8'h00);
    @(posedge clk) can_mode <= 2'h2;
    cyc(6);
    chk(bus_stat, 8'h01);
    @(posedge clk) can_mode <= dbs_pkg::TRX_NORMAL;
    cyc(6);
    chk({7'h0, can_tx_en}, 8'h00);
    @(posedge clk) can_supply_low <= 1'b0;
    cyc(6);
    acc(BUS, 1'b1, 8'h01);
    chk(bus_stat, 8'h00);
    chk({7'h0, can_tx_en}, 8'h01);
  endtask
  task automatic t_swk;
    @(posedge clk) swk_active <= 1'b1;
    @(posedge clk) swk_enable_req <= 1'b1;
    cyc(1);
    chk({7'h0, swk_enable}, 8'h01);
    pulse(11);
    chk(bus_stat, 8'h08);
    chk({7'h0, swk_enable}, 8'h00);
    pulse(10);
    chk(bus_stat, 8'h18);
    acc(BUS, 1'b1, 8'h18);
    chk(bus_stat, 8'h00);
    chk({7'h0, swk_enable}, 8'h01);
  endtask
  initial begin
    {sys_rst, can_txd, lin_txd} = 3'h7;
    {ev, dev_config, can_mode, lin_mode, fail_cfg_bit, wd_stop_by_fail, swk_active} = '0;
    {can_bus_dom, lin_bus_dom, can_tsd, lin_tsd, can_supply_low, lin_supply_low} = '0;
    swk_enable_req = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(4);
    t_reset();
    t_state();
    t_wd();
    t_spi();
    t_trx();
    t_supply();
    t_swk();
    wrap_up();
  end
endmodule
